// [watchdog_reset_status.v]
`include "watchdog_reset_status_regs.vh"

module watchdog_reset_status #(
  parameter [21:0] WDT_BASE_CYCLES = `WDT_BASE_OSC_CYCLES
) (
  // clock and power-on reset
  input  wire        mclk_in,
  input  wire        arst_n_in,
  // axi4-lite write address
  input  wire [31:0] awaddr_in,
  input  wire        awvalid_in,
  output wire        awready_out,
  // axi4-lite write data
  input  wire [31:0] wdata_in,
  input  wire [3:0]  wstrb_in,
  input  wire        wvalid_in,
  output wire        wready_out,
  // axi4-lite write response
  output wire [1:0]  bresp_out,
  output wire        bvalid_out,
  input  wire        bready_in,
  // axi4-lite read address
  input  wire [31:0] araddr_in,
  input  wire        arvalid_in,
  output wire        arready_out,
  // axi4-lite read data
  output wire [31:0] rdata_out,
  output wire [1:0]  rresp_out,
  output wire        rvalid_out,
  input  wire        rready_in,
  // watchdog and reset sources
  input  wire        wdt_osc_in,
  input  wire        wdt_restart_in,
  input  wire        watchdog_always_on_fuse_in,
  input  wire        ext_reset_in,
  input  wire        brownout_reset_in,
  input  wire        scan_reset_in,
  output wire        watchdog_reset_out
);

  // register select: bit 0 status, bit 1 control, none is unmapped
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      reg_sel = 2'h0;
      if (addr == `STATUS_OFFSET)
        reg_sel = 2'h1;
      else if (addr == `CONTROL_OFFSET)
        reg_sel = 2'h2;
    end
  endfunction

  // timeout length in oscillator cycles
  function [21:0] period_limit;
    input [2:0] sel;
    begin
      period_limit = WDT_BASE_CYCLES << sel;
    end
  endfunction

  // write strobe of one register, taken with the write response
  function reg_wr;
    input       fire;
    input       strb;
    input [1:0] sel;
    input [1:0] want;
    begin
      reg_wr = fire & strb & (sel == want);
    end
  endfunction

  // two-stage synchronisers: osc, ext, brownout, scan, fuse
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg         osc_prev_q;
  wire        osc_s;
  wire        ext_s;
  wire        bor_s;
  wire        scan_s;
  wire        fuse_s;
  wire        osc_tick;

  // bus state
  reg         awready_q;
  reg         wready_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg  [31:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg         w_strb_q;
  reg         arready_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  // block state
  reg  [4:0]  status_q;
  reg  [4:0]  status_d;
  reg         en_q;
  reg         en_d;
  reg         ce_q;
  reg         ce_d;
  reg  [2:0]  ce_cnt_q;
  reg  [2:0]  ce_cnt_d;
  reg  [2:0]  period_q;
  reg  [2:0]  period_d;
  reg  [21:0] wdt_cnt_q;
  reg  [21:0] wdt_cnt_d;
  reg         wdt_rst_q;
  reg         wdt_rst_d;

  wire        wr_fire;
  wire [1:0]  wr_sel;
  wire [1:0]  rd_sel;
  wire        wdt_on;
  wire        chip_rst;
  wire [4:0]  set_vec;
  wire        status_wr;
  wire        control_wr;
  reg  [31:0] rd_word;

  assign osc_s  = sync2_q[4];
  assign ext_s  = sync2_q[3];
  assign bor_s  = sync2_q[2];
  assign scan_s = sync2_q[1];
  assign fuse_s = sync2_q[0];

  assign osc_tick = osc_s & ~osc_prev_q; // RL19

  assign wr_fire  = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_sel   = reg_sel(aw_addr_q);
  assign rd_sel   = reg_sel(araddr_in);

  assign status_wr  = reg_wr(wr_fire, w_strb_q, wr_sel, 2'h1);
  assign control_wr = reg_wr(wr_fire, w_strb_q, wr_sel, 2'h2);

  assign wdt_on   = en_q | fuse_s; // RL14
  assign chip_rst = ext_s | bor_s | scan_s | wdt_rst_q;

  // sources that set flags this cycle; power-on is the async reset
  assign set_vec = {scan_s, wdt_rst_q, bor_s, ext_s, 1'b0}; // RL1 RL2 RL3 RL4

  assign awready_out        = awready_q;
  assign wready_out         = wready_q;
  assign bvalid_out         = bvalid_q;
  assign bresp_out          = bresp_q;
  assign arready_out        = arready_q;
  assign rvalid_out         = rvalid_q;
  assign rdata_out          = rdata_q;
  assign rresp_out          = rresp_q;
  assign watchdog_reset_out = wdt_rst_q;

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync1_q    <= 5'h00;
      sync2_q    <= 5'h00;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q    <= {wdt_osc_in, ext_reset_in, brownout_reset_in,
                     scan_reset_in, watchdog_always_on_fuse_in};
      sync2_q    <= sync1_q;
      osc_prev_q <= osc_s;
    end
  end

  // write channel: take address and data in either order
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      aw_addr_q <= 32'h0000_0000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 1'b0;
    end
    else
    begin
      if (awready_q && awvalid_in)
      begin
        awready_q <= 1'b0;
        aw_addr_q <= awaddr_in;
      end
      if (wready_q && wvalid_in)
      begin
        wready_q <= 1'b0;
        w_data_q <= wdata_in;
        w_strb_q <= wstrb_in[0];
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_q && bready_in)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read data view
  always @*
  begin
    rd_word = 32'h0000_0000;
    if (rd_sel == 2'h1)
      rd_word[4:0] = status_q;
    else if (rd_sel == 2'h2)
    begin
      rd_word[`CHANGE_EN_BIT] = ce_q;
      rd_word[`ENABLE_BIT]    = wdt_on; // RL18
      rd_word[`PERIOD_MSB:0]  = period_q;
      rd_word[7:5]            = 3'h0; // RL8
    end
  end

  // read channel: one read at a time, data one cycle after address
  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end
    else
    begin
      if (arready_q && arvalid_in)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= (rd_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid_q && rready_in)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // reset-cause flags: zero-write clears, set wins over clear
  always @*
  begin
    status_d = status_q;
    if (status_wr)
      status_d = status_q & w_data_q[4:0]; // RL5 RL6 RL20
    status_d = status_d | set_vec;
  end

  // control register and change window
  always @*
  begin
    en_d     = en_q;
    ce_d     = ce_q;
    ce_cnt_d = ce_cnt_q;
    period_d = period_q;
    if (chip_rst)
    begin
      en_d     = 1'b0;
      ce_d     = 1'b0;
      ce_cnt_d = 3'h0;
      period_d = `PERIOD_RESET;
    end
    else
    begin
      if (ce_q)
      begin
        if (ce_cnt_q == 3'h0)
          ce_d = 1'b0; // RL9
        else
          ce_cnt_d = ce_cnt_q - 3'h1;
      end
      if (control_wr)
      begin
        if (w_data_q[`ENABLE_BIT])
          en_d = 1'b1; // RL12
        else if (ce_q && !fuse_s)
          en_d = 1'b0; // RL10 RL13 RL14
        if (ce_q)
          period_d = w_data_q[`PERIOD_MSB:0]; // RL11
        if (w_data_q[`CHANGE_EN_BIT])
        begin
          ce_d     = 1'b1;
          ce_cnt_d = `CHANGE_WINDOW_CYCLES - 3'h1; // RL9
        end
        else
          ce_d = 1'b0;
      end
    end
  end

  // watchdog counter and timeout pulse
  always @*
  begin
    wdt_cnt_d = wdt_cnt_q;
    wdt_rst_d = 1'b0;
    if (chip_rst || wdt_restart_in || !wdt_on)
      wdt_cnt_d = 22'h00_0000; // RL17
    else if (osc_tick)
    begin
      // at or past the limit, so a shortened period still expires
      if (wdt_cnt_q >= period_limit(period_q) - 22'h00_0001) // RL15
      begin
        wdt_cnt_d = 22'h00_0000;
        wdt_rst_d = 1'b1; // RL16
      end
      else
        wdt_cnt_d = wdt_cnt_q + 22'h00_0001; // RL19
    end
  end

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status_q  <= `STATUS_RESET; // RL5
      en_q      <= 1'b0;
      ce_q      <= 1'b0;
      ce_cnt_q  <= 3'h0;
      period_q  <= `PERIOD_RESET;
      wdt_cnt_q <= 22'h00_0000;
      wdt_rst_q <= 1'b0;
    end
    else
    begin
      status_q  <= status_d;
      en_q      <= en_d;
      ce_q      <= ce_d;
      ce_cnt_q  <= ce_cnt_d;
      period_q  <= period_d;
      wdt_cnt_q <= wdt_cnt_d;
      wdt_rst_q <= wdt_rst_d;
    end
  end

endmodule

// [watchdog_reset_status_regs.vh]
// Summary of operation
// (RL1) scan-chain reset sets scan port reset flag
// (RL2) watchdog timeout sets watchdog reset flag
// (RL3) brown-out reset sets brown-out reset flag
// (RL4) external pin reset sets external reset flag
// (RL5) power-on sets its flag; only software clears
// (RL6) other flags cleared by power-on or zero-write
// (RL7) software reads then clears flags early
// (RL8) control bits 7:5 always read zero
// (RL9) change enable self-clears after four cycles
// (RL10) enable clears only while change enable set
// (RL11) period select changes only under change enable
// (RL12) writing one enables, accepted zero disables
// (RL13) software disables via two writes within window
// (RL14) always-on level ignores every disable attempt
// (RL15) period codes select 16K doubling to 2048K
// (RL16) timeout gives one-cycle watchdog reset pulse
// (RL17) count restarts on restart, disable, reset
// (RL18) always-on level reads enable as one
// (RL19) counter advances on watchdog oscillator rising edges
// (RL20) writing one to a flag leaves it
`ifndef WATCHDOG_RESET_STATUS_REGS_VH
`define WATCHDOG_RESET_STATUS_REGS_VH

// register byte offsets
`define STATUS_OFFSET     32'h0000_0000
`define CONTROL_OFFSET    32'h0000_0004

// reset-cause status fields
`define SCAN_FLAG_BIT     4
`define WDT_FLAG_BIT      3
`define BROWNOUT_FLAG_BIT 2
`define EXT_FLAG_BIT      1
`define POR_FLAG_BIT      0
`define STATUS_RESET      5'h01

// watchdog control fields
`define CHANGE_EN_BIT     4
`define ENABLE_BIT        3
`define PERIOD_MSB        2
`define PERIOD_RESET      3'h0

// timing counts
`define CHANGE_WINDOW_CYCLES 3'h4
`define WDT_BASE_OSC_CYCLES  22'h00_4000

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [watchdog_reset_status_props.sv]
module watchdog_reset_status_checker (
  // clock and reset
  input wire        mclk_in,
  input wire        arst_n_in,
  // bus handshakes and read data
  input wire        awvalid_in,
  input wire        awready_out,
  input wire        wvalid_in,
  input wire        wready_out,
  input wire        bvalid_out,
  input wire        bready_in,
  input wire        arvalid_in,
  input wire        arready_out,
  input wire        rvalid_out,
  input wire        rready_in,
  input wire [31:0] rdata_out,
  // watchdog and external reset
  input wire        watchdog_reset_out,
  input wire        ext_reset_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_pulse;
    $rose(watchdog_reset_out) |=> !watchdog_reset_out [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_rsv;
    rvalid_out |-> rdata_out[31:5] == 27'h000_0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rhold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold;
    bvalid_out && !bready_in |=> bvalid_out;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rlat;
    arvalid_in && arready_out |=> rvalid_out;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    awvalid_in && awready_out && wvalid_in && wready_out |=> ##1 bvalid_out;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_busy;
    bvalid_out |-> !awready_out && !wready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("second write taken");
  property p_chip;
    ext_reset_in [*6] |-> !watchdog_reset_out;
  endproperty
  a_chip: assert property (p_chip) else $error("timeout during reset");
  c_pulse: cover property (watchdog_reset_out);
  c_rd: cover property (rvalid_out && rready_in);
  c_wr: cover property (bvalid_out && bready_in);
endmodule
bind watchdog_reset_status watchdog_reset_status_checker i_watchdog_reset_status_checker (
  .mclk_in, .arst_n_in, .awvalid_in, .awready_out, .wvalid_in, .wready_out,
  .bvalid_out, .bready_in, .arvalid_in, .arready_out, .rvalid_out, .rready_in,
  .rdata_out, .watchdog_reset_out, .ext_reset_in);

// [watchdog_reset_status_tb_top.sv]
module watchdog_reset_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 0, arst_n_in = 0, wdt_osc_in = 0, watchdog_always_on_fuse_in = 0;
  logic        wdt_restart_in = 0;
  logic [31:0] awaddr_in = 0, wdata_in = 0, araddr_in = 0;
  logic        awvalid_in = 0, wvalid_in = 0, bready_in = 0, arvalid_in = 0, rready_in = 0;
  logic [2:0]  src = 0;
  wire         awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  wire         watchdog_reset_out;
  wire  [1:0]  bresp_out, rresp_out;
  wire  [31:0] rdata_out;
  int          failures = 0, checked = 0, cyc = 0, t0;
  always #5 mclk_in = ~mclk_in;
  watchdog_reset_status #(.WDT_BASE_CYCLES(22'h00_0004)) i_watchdog_reset_status (
    .mclk_in, .arst_n_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
    .wstrb_in(4'h1), .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
    .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out,
    .rready_in, .wdt_osc_in, .wdt_restart_in, .watchdog_always_on_fuse_in,
    .ext_reset_in(src[0]), .brownout_reset_in(src[1]), .scan_reset_in(src[2]),
    .watchdog_reset_out);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1;
    wvalid_in <= 1;
    bready_in <= 1;
    do
    begin
      @(posedge mclk_in);
      if (awready_out) awvalid_in <= 0;
      if (wready_out) wvalid_in <= 0;
    end while (!bvalid_out);
    chk(bresp_out, a > 4 ? 2 : 0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    araddr_in <= a;
    arvalid_in <= 1;
    rready_in <= 1;
    do
    begin
      @(posedge mclk_in);
      if (arready_out) arvalid_in <= 0;
    end while (!rvalid_out);
    chk(rdata_out, e);
    chk(rresp_out, a > 4 ? 2 : 0);
  endtask
  task automatic hit(input int i);
    src[i] <= 1;
    repeat (6) @(posedge mclk_in);
    src[i] <= 0;
    repeat (4) @(posedge mclk_in);
  endtask
  task end_of_test;
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc % 50 == 49)
      wdt_osc_in <= ~wdt_osc_in;
    if (cyc == 6000)
    begin
      failures++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1;
    @(posedge mclk_in);
    rd(0, 1);
    rd(4, 0);
    hit(0);
    rd(0, 3);
    wr(0, 32'h0000_001f);
    rd(0, 3);
    rd(8, 0);
    wr(8, 32'h0000_0008);
    wr(0, 0);
    rd(0, 0);
    hit(0);
    rd(0, 2);
    hit(1);
    rd(0, 6);
    hit(2);
    rd(0, 32'h0000_0016);
    wr(0, 0);
    rd(0, 0);
    wr(4, 8);
    rd(4, 8);
    wr(4, 0);
    rd(4, 8);
    wr(4, 32'h0000_000f);
    rd(4, 8);
    wr(4, 32'h0000_0018);
    rd(4, 32'h0000_0018);
    rd(4, 32'h0000_0018);
    wr(4, 32'h0000_0018);
    @(posedge mclk_in);
    rd(4, 32'h0000_0018);
    rd(4, 8);
    wr(4, 32'h0000_0018);
    wr(4, 3);
    rd(4, 3);
    wr(4, 32'h0000_0018);
    wr(4, 32'h0000_0008);
    repeat (6)
    begin
      repeat (150) @(posedge mclk_in);
      wdt_restart_in <= 1;
      @(posedge mclk_in);
      wdt_restart_in <= 0;
    end
    rd(0, 0);
    wr(4, 32'h0000_0018);
    wr(4, 0);
    wr(4, 32'h0000_0018);
    wr(4, 32'h0000_000a);
    t0 = cyc;
    while (!watchdog_reset_out && cyc < t0 + 3000) @(posedge mclk_in);
    chk(cyc - t0 > 1450 && cyc - t0 < 1650, 1);
    @(posedge mclk_in);
    rd(0, 8);
    rd(4, 0);
    watchdog_always_on_fuse_in <= 1;
    repeat (4) @(posedge mclk_in);
    rd(4, 8);
    wr(4, 32'h0000_0018);
    wr(4, 2);
    rd(4, 32'h0000_000a);
    arst_n_in <= 0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1;
    @(posedge mclk_in);
    rd(0, 1);
    end_of_test;
  end
endmodule
